/* File: logic/jhnf_fabric.sv */
/*
 * scan hub with attached nodes and a small fifo for updated node data.
 * assumes tck, tms, tdi and trst arrive from pins, asynchronous to clk_i,
 * with tck much slower than clk_i (at least four clk_i per tck phase).
 */
`timescale 1ns/1ps

// fifo between the hub and user logic
module jhnf_fifo #(
    parameter int W = 16,
    parameter int D = 4
) (
    input  wire logic         clk_i,
    input  wire logic         reset_n_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;   // storage words
        logic [AW-1:0]       wr;    // write pointer
        logic [AW-1:0]       rd;    // read pointer
        logic [AW:0]         cnt;   // words held
        logic                vld;   // registered not-empty flag
        logic [W-1:0]        head;  // registered head word
    } jhnf_fifo_s;
    jhnf_fifo_s r, next_r;
    logic push, pop;

    assign in_ready_o  = (r.cnt != (AW+1)'(D));   // honest full
    assign out_valid_o = r.vld;                   // straight from a flop
    assign out_data_o  = r.head;                  // straight from a flop

    // pointer and count update
    always_comb begin
        next_r = r;
        push   = in_valid_i && in_ready_o;
        pop    = out_valid_o && out_ready_i;
        if (push) begin
            next_r.mem[r.wr] = in_data_i;
            next_r.wr        = (r.wr == AW'(D-1)) ? '0 : r.wr + 1'b1;
        end
        if (pop) begin
            next_r.rd = (r.rd == AW'(D-1)) ? '0 : r.rd + 1'b1;
        end
        next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // head and empty flag registered so the outputs need no logic
        next_r.vld  = (next_r.cnt != '0);
        next_r.head = next_r.mem[next_r.rd];
    end

    // state register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule

module jhnf_fabric
    import jhnf_pkg::*;
#(
    parameter int NODES      = jhnf_pkg::NODES_DEF,   // nodes on the hub
    parameter int VIR_W      = jhnf_pkg::VIR_W_DEF,   // node instr width
    parameter int DATA_W     = jhnf_pkg::DATA_W_DEF,  // node data width
    parameter int FIFO_D     = jhnf_pkg::FIFO_D_DEF,  // fifo depth
    parameter bit HAS_TRST   = 1'b1,                  // test reset fitted
    parameter bit SHOW_HARD  = 1'b1                   // expose hard states
) (
    input  wire logic                     clk_i,
    input  wire logic                     reset_n_i,
    input  wire logic                     tck_i,
    input  wire logic                     tms_i,
    input  wire logic                     tdi_i,
    input  wire logic                     trst_n_i,
    output logic                          tdo_o,
    output logic                          tdi_o,
    output logic                          tms_o,
    output logic [15:0]                   jtag_state_o,
    output logic [jhnf_pkg::VS_W-1:0]     virtual_state_o,
    output logic [NODES-1:0]              node_enable_o,
    output logic [NODES*VIR_W-1:0]        node_instr_parallel_out_o,
    input  wire logic [NODES*VIR_W-1:0]   node_instr_capture_port_i,
    input  wire logic [NODES*DATA_W-1:0]  node_data_capture_i,
    output logic                          data_valid_o,
    input  wire logic                     data_ready_i,
    output logic [jhnf_pkg::ADDR_W+DATA_W-1:0] data_word_o
);
    localparam int VSH_W = ADDR_W + VIR_W;   // virtual instr scan width
    localparam int WD_W  = ADDR_W + DATA_W;  // fifo word: node and data

    typedef struct packed {
        logic [2:0]                    tck_s;  // sync pair plus edge delay
        logic [1:0]                    tms_s;  // tms synchroniser
        logic [1:0]                    tdi_s;  // tdi synchroniser
        logic [1:0]                    trst_s; // test reset synchroniser
        jhnf_tap_e                     tap;    // hub copy of the tap
        logic [IR_W-1:0]               ir_sh;  // ir shift stage
        logic [IR_W-1:0]               ir;     // ir hold stage
        logic                          byp;    // bypass chain
        logic [VSH_W-1:0]              vir_sh; // virtual instr shift stage
        logic [ADDR_W-1:0]             sel;    // selected node, 0 = none
        logic [NODES-1:0][VIR_W-1:0]   vir;    // node instr hold stages
        logic [NODES-1:0][DATA_W-1:0]  dr_sh;  // node data chains
        logic                          pend;   // word waiting for fifo
        logic [WD_W-1:0]               word;   // pending node and data
        logic [VS_W-1:0]               vst;    // virtual state outputs
        logic [NODES-1:0]              ena;    // per-node enables
        logic                          tdo;    // serial output
        logic                          tms;    // tms echo
    } jhnf_top_s;
    jhnf_top_s r, next_r;

    logic rise;      // tck rising edge seen
    logic fall;      // tck falling edge seen
    logic tms;       // synchronised tms
    logic tdi;       // synchronised tdi
    logic fifo_rdy;  // fifo accepts pending word
    logic vok;       // current selection names a node

    // tap transition table
    function automatic jhnf_tap_e tap_next(input jhnf_tap_e s, input logic m);
        unique case (s)
            ST_TLR:  tap_next = m ? ST_TLR  : ST_RTI;
            ST_RTI:  tap_next = m ? ST_SDRS : ST_RTI;
            ST_SDRS: tap_next = m ? ST_SIRS : ST_CDR;
            ST_CDR:  tap_next = m ? ST_E1DR : ST_SDR;
            ST_SDR:  tap_next = m ? ST_E1DR : ST_SDR;
            ST_E1DR: tap_next = m ? ST_UDR  : ST_PDR;
            ST_PDR:  tap_next = m ? ST_E2DR : ST_PDR;
            ST_E2DR: tap_next = m ? ST_UDR  : ST_SDR;
            ST_UDR:  tap_next = m ? ST_SDRS : ST_RTI;
            ST_SIRS: tap_next = m ? ST_TLR  : ST_CIR;
            ST_CIR:  tap_next = m ? ST_E1IR : ST_SIR;
            ST_SIR:  tap_next = m ? ST_E1IR : ST_SIR;
            ST_E1IR: tap_next = m ? ST_UIR  : ST_PIR;
            ST_PIR:  tap_next = m ? ST_E2IR : ST_PIR;
            ST_E2IR: tap_next = m ? ST_UIR  : ST_SIR;
            ST_UIR:  tap_next = m ? ST_SDRS : ST_RTI;
            default: tap_next = ST_TLR;      // illegal code recovers
        endcase
    endfunction

    // does an address name an attached node
    function automatic logic node_ok(input logic [ADDR_W-1:0] a);
        node_ok = (a != '0) && (32'(a) <= NODES);
    endfunction

    assign rise  = r.tck_s[1] && !r.tck_s[2];
    assign fall  = !r.tck_s[1] && r.tck_s[2];
    assign tms   = r.tms_s[1];
    assign tdi   = r.tdi_s[1];
    assign vok   = node_ok(r.sel);

    // hub and node behaviour on sampled tck edges
    always_comb begin
        next_r        = r;
        next_r.tck_s  = {r.tck_s[1:0], tck_i};
        next_r.tms_s  = {r.tms_s[0], tms_i};
        next_r.tdi_s  = {r.tdi_s[0], tdi_i};
        next_r.trst_s = {r.trst_s[0], HAS_TRST ? trst_n_i : 1'b1};
        if (r.pend && fifo_rdy) begin
            next_r.pend = 1'b0;                          // word handed over
        end
        if (rise) begin
            next_r.tap = tap_next(r.tap, tms);
            next_r.tms = tms;
            unique case (r.tap)
                ST_CIR: next_r.ir_sh = {{(IR_W-2){1'b0}}, IR_CAPTURE};
                ST_SIR: next_r.ir_sh = {tdi, r.ir_sh[IR_W-1:1]};
                ST_UIR: next_r.ir    = r.ir_sh;
                default: begin
                end
            endcase
            // ir value addresses exactly one chain
            if (r.ir == IR_INSTR_PATH) begin
                unique case (r.tap)
                    ST_CDR: begin
                        next_r.vir_sh = {r.sel, {VIR_W{1'b0}}};
                        for (int i = 0; i < NODES; i++) begin
                            if (r.ena[i]) begin
                                next_r.vir_sh[VIR_W-1:0] =
                                    node_instr_capture_port_i[i*VIR_W +: VIR_W];
                            end
                        end
                    end
                    ST_SDR: next_r.vir_sh = {tdi, r.vir_sh[VSH_W-1:1]};
                    ST_UDR: begin
                        next_r.sel = r.vir_sh[VSH_W-1:VIR_W];
                        for (int i = 0; i < NODES; i++) begin
                            if (32'(r.vir_sh[VSH_W-1:VIR_W]) == i + 1) begin
                                next_r.vir[i] = r.vir_sh[VIR_W-1:0];
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (r.ir == IR_DATA_PATH && vok) begin
                for (int i = 0; i < NODES; i++) begin
                    if (r.ena[i]) begin
                        unique case (r.tap)
                            ST_CDR: next_r.dr_sh[i] =
                                node_data_capture_i[i*DATA_W +: DATA_W];
                            ST_SDR: next_r.dr_sh[i] =
                                {tdi, r.dr_sh[i][DATA_W-1:1]};
                            ST_UDR: begin
                                if (!r.pend || fifo_rdy) begin
                                    next_r.pend = 1'b1;  // set wins over clear
                                    next_r.word = {r.sel, r.dr_sh[i]};
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end else begin
                // all other codes reach the one-bit bypass chain
                if (r.tap == ST_CDR) begin
                    next_r.byp = 1'b0;
                end else if (r.tap == ST_SDR) begin
                    next_r.byp = tdi;
                end
            end
        end
        if (fall) begin
            // tdo follows the chain the ir addresses
            if (r.tap == ST_SIR) begin
                next_r.tdo = r.ir_sh[0];
            end else if (r.tap == ST_SDR) begin
                if (r.ir == IR_INSTR_PATH) begin
                    next_r.tdo = r.vir_sh[0];
                end else if (r.ir == IR_DATA_PATH && vok) begin
                    next_r.tdo = 1'b0;
                    for (int i = 0; i < NODES; i++) begin
                        if (r.ena[i]) begin
                            next_r.tdo = r.dr_sh[i][0];
                        end
                    end
                end else begin
                    next_r.tdo = r.byp;
                end
            end
        end
        if (!r.trst_s[1]) begin
            next_r.tap = ST_TLR;
        end
        if (next_r.tap == ST_TLR) begin
            next_r.ir  = IR_RESET;
            next_r.sel = SEL_RESET;
        end
        // broadcast enables and virtual states
        for (int i = 0; i < NODES; i++) begin
            next_r.ena[i] = (32'(next_r.sel) == i + 1);
        end
        next_r.vst = '0;
        if (next_r.ir == IR_INSTR_PATH) begin
            next_r.vst[VS_CIR] = (next_r.tap == ST_CDR);
            next_r.vst[VS_UIR] = (next_r.tap == ST_UDR);
        end else if (next_r.ir == IR_DATA_PATH && node_ok(next_r.sel)) begin
            next_r.vst[VS_CDR]  = (next_r.tap == ST_CDR);
            next_r.vst[VS_SDR]  = (next_r.tap == ST_SDR);
            next_r.vst[VS_E1DR] = (next_r.tap == ST_E1DR);
            next_r.vst[VS_PDR]  = (next_r.tap == ST_PDR);
            next_r.vst[VS_E2DR] = (next_r.tap == ST_E2DR);
            next_r.vst[VS_UDR]  = (next_r.tap == ST_UDR);
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r        <= '0;
            r.tap    <= ST_TLR;
            r.ir     <= IR_RESET;
            r.ir_sh  <= IR_RESET;
            r.trst_s <= 2'h3;
        end else begin
            r <= next_r;
        end
    end

    // fifo holds updated node data until user logic drains it
    jhnf_fifo #(.W(WD_W), .D(FIFO_D)) u_fifo (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (r.pend),
        .in_ready_o  (fifo_rdy),
        .in_data_i   (r.word),
        .out_valid_o (data_valid_o),
        .out_ready_i (data_ready_i),
        .out_data_o  (data_word_o)
    );

    // outputs from the state register
    assign tdo_o                     = r.tdo;
    assign tdi_o                     = r.tdi_s[1];
    assign tms_o                     = SHOW_HARD ? r.tms : 1'b0;
    assign jtag_state_o              = SHOW_HARD ? r.tap : 16'h0000;
    assign virtual_state_o           = r.vst;
    assign node_enable_o             = r.ena;
    assign node_instr_parallel_out_o = r.vir;
endmodule

/* File: logic/jhnf_pkg.sv */
/*
 * shared constants for the scan hub and node fabric.
 * assumes a test access port sampled on the fabric clock.
 */
package jhnf_pkg;
    localparam int IR_W          = 10;            // hard instruction width
    localparam logic [9:0] IR_DATA_PATH  = 10'h00c; // data_path_user_instr code
    localparam logic [9:0] IR_INSTR_PATH = 10'h00e; // instr_path_user_instr code
    localparam logic [9:0] IR_RESET      = 10'h3ff; // bypass after reset
    localparam logic [1:0] IR_CAPTURE    = 2'h1;    // fixed ir capture bits
    localparam int ADDR_W        = 8;             // node address, up to 255
    localparam int NODES_DEF     = 2;             // default node count
    localparam int VIR_W_DEF     = 4;             // default node instr width
    localparam int DATA_W_DEF    = 8;             // default node data width
    localparam int FIFO_D_DEF    = 4;             // words in the data fifo
    localparam logic [7:0] SEL_RESET = 8'h00;     // no node selected
    // virtual state bit positions
    localparam int VS_CDR  = 0;
    localparam int VS_SDR  = 1;
    localparam int VS_E1DR = 2;
    localparam int VS_PDR  = 3;
    localparam int VS_E2DR = 4;
    localparam int VS_UDR  = 5;
    localparam int VS_CIR  = 6;
    localparam int VS_UIR  = 7;
    localparam int VS_W    = 8;
    // one-hot tap states
    typedef enum logic [15:0] {
        ST_TLR  = 16'h0001, ST_RTI  = 16'h0002, ST_SDRS = 16'h0004,
        ST_CDR  = 16'h0008, ST_SDR  = 16'h0010, ST_E1DR = 16'h0020,
        ST_PDR  = 16'h0040, ST_E2DR = 16'h0080, ST_UDR  = 16'h0100,
        ST_SIRS = 16'h0200, ST_CIR  = 16'h0400, ST_SIR  = 16'h0800,
        ST_E1IR = 16'h1000, ST_PIR  = 16'h2000, ST_E2IR = 16'h4000,
        ST_UIR  = 16'h8000
    } jhnf_tap_e;
endpackage

/* File: bench/jhnf_fabric_sva.sv */
/* checker for the scan hub fabric: tap decode, virtual states, enables, fifo.
   bound into jhnf_fabric; assumes the hard states are shown and trst is fitted. */
`timescale 1ns/1ps
module jhnf_fabric_sva
    import jhnf_pkg::*;
#(
    parameter int NODES  = 2,   // nodes on the hub
    parameter int VIR_W  = 4,   // node instr width
    parameter int DATA_W = 8    // node data width
) (
    input wire logic                               clk_i,
    input wire logic                               reset_n_i,
    input wire logic                               tdi_i,
    input wire logic                               trst_n_i,
    input wire logic                               tdi_o,
    input wire logic [15:0]                        jtag_state_o,
    input wire logic [jhnf_pkg::VS_W-1:0]          virtual_state_o,
    input wire logic [NODES-1:0]                   node_enable_o,
    input wire logic [NODES*VIR_W-1:0]             node_instr_parallel_out_o,
    input wire logic                               data_valid_o,
    input wire logic                               data_ready_i,
    input wire logic [jhnf_pkg::ADDR_W+DATA_W-1:0] data_word_o
);
    import jhnf_pkg::*;
    // all checks on the fabric clock, idle while reset is low
    default clocking cb_main @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_tap_onehot; $onehot(jtag_state_o); endproperty
    a_tap_onehot: assert property (p_tap_onehot) else $error("tap state not one-hot");
    property p_vs_onehot; $onehot0(virtual_state_o); endproperty
    a_vs_onehot: assert property (p_vs_onehot) else $error("virtual states overlap");
    property p_en_onehot; $onehot0(node_enable_o); endproperty
    a_en_onehot: assert property (p_en_onehot) else $error("several nodes enabled");
    property p_vcir_cdr; virtual_state_o[VS_CIR] |-> jtag_state_o == ST_CDR; endproperty
    a_vcir_cdr: assert property (p_vcir_cdr) else $error("vcir outside capture");
    property p_vuir_udr; virtual_state_o[VS_UIR] |-> jtag_state_o == ST_UDR; endproperty
    a_vuir_udr: assert property (p_vuir_udr) else $error("vuir outside update");
    property p_vsdr_sdr; virtual_state_o[VS_SDR] |-> jtag_state_o == ST_SDR; endproperty
    a_vsdr_sdr: assert property (p_vsdr_sdr) else $error("vsdr outside shift");
    property p_vcdr_sel; virtual_state_o[VS_CDR] |-> jtag_state_o == ST_CDR && |node_enable_o;
    endproperty
    a_vcdr_sel: assert property (p_vcdr_sel) else $error("vcdr without node");
    property p_tlr_idle; jtag_state_o == ST_TLR |-> virtual_state_o == '0; endproperty
    a_tlr_idle: assert property (p_tlr_idle) else $error("vstate in reset state");
    property p_tlr_desel; jtag_state_o == ST_TLR [*3] |-> node_enable_o == '0; endproperty
    a_tlr_desel: assert property (p_tlr_desel) else $error("node kept in reset");
    property p_trst; !trst_n_i [*5] |-> jtag_state_o == ST_TLR; endproperty
    a_trst: assert property (p_trst) else $error("test reset ignored");
    property p_instr_hold; $changed(node_instr_parallel_out_o)
        |-> $past(virtual_state_o[VS_UIR]) || $past(virtual_state_o[VS_UIR], 2); endproperty
    a_instr_hold: assert property (p_instr_hold) else $error("instr out moved");
    property p_en_change; $changed(node_enable_o) |-> jtag_state_o == ST_TLR
        || $past(virtual_state_o[VS_UIR]) || $past(virtual_state_o[VS_UIR], 2); endproperty
    a_en_change: assert property (p_en_change) else $error("enable moved");
    property p_tdi_pass; $stable(tdi_i) [*5] |-> tdi_o == tdi_i; endproperty
    a_tdi_pass: assert property (p_tdi_pass) else $error("tdi broadcast broken");
    property p_fifo_stand; data_valid_o && !data_ready_i |=> data_valid_o && $stable(data_word_o);
    endproperty
    a_fifo_stand: assert property (p_fifo_stand) else $error("fifo word lost");
endmodule

bind jhnf_fabric jhnf_fabric_sva #(.NODES(NODES), .VIR_W(VIR_W), .DATA_W(DATA_W)) i_sva (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .tdi_i(tdi_i), .trst_n_i(trst_n_i),
    .tdi_o(tdi_o), .jtag_state_o(jtag_state_o), .virtual_state_o(virtual_state_o),
    .node_enable_o(node_enable_o), .node_instr_parallel_out_o(node_instr_parallel_out_o),
    .data_valid_o(data_valid_o), .data_ready_i(data_ready_i), .data_word_o(data_word_o));

/* File: bench/jhnf_host.sv */
/* test host model: drives tck, tms and tdi, samples tdo at each tck rise.
   assumes clk_i at 100 MHz; a tck period is 16 clk_i, tck idles low. */
`timescale 1ns/1ps
module jhnf_host (
    input  wire logic clk_i,    // fabric clock, paces the link
    input  wire logic tdo_i,    // serial data from the fabric
    output logic      tck_o,    // test clock, still outside frames
    output logic      tms_o,    // test mode select
    output logic      tdi_o     // serial data to the fabric
);
    // pins idle in reset-leaning levels
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // one tck period; tdo taken just before the rise
    task automatic tick(input logic m, input logic d, output logic q);
        tms_o <= m;
        tdi_o <= d;
        repeat (8) @(negedge clk_i);
        q = tdo_i;
        tck_o <= 1'b1;
        repeat (8) @(negedge clk_i);
        tck_o <= 1'b0;
    endtask

    // idle -> capture -> shift n bits lsb first -> update -> idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = '0;
        tick(1'b1, ~tdi_o, q);            // select data scan
        if (ir) begin
            tick(1'b1, ~tdi_o, q);        // select instr scan
        end
        tick(1'b0, ~tdi_o, q);            // capture
        tick(1'b0, ~tdi_o, q);            // enter shift
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);  // virtual traffic in a plain scan
            dout[i] = q;
        end
        tick(1'b1, ~tdi_o, q);            // update, released line toggles
        tick(1'b0, ~tdi_o, q);            // back to idle
    endtask
endmodule

/* File: bench/jhnf_fabric_tb.sv */
/* self-checking bench for jhnf_fabric with the test host model.
   assumes NODES 2, VIR_W 4, DATA_W 8, fifo of 4 words. */
`timescale 1ns/1ps
module jhnf_fabric_tb;
    import jhnf_pkg::*;
    typedef struct packed {
        logic [7:0] node;   // node address selected
        logic [3:0] vir;    // node instr shifted in
        logic [7:0] data;   // node data shifted in
        logic [1:0] en;     // expected enable bank
    } jhnf_row_s;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        trst_n_i = 1'b1;
    logic        data_ready_i = 1'b0;
    logic [7:0]  cap_port = 8'h96;      // node2 9, node1 6
    logic [15:0] data_cap;              // user data chains, picked by instr
    logic        tck, tms, tdi, tdo_o, tdi_o, tms_o, data_valid_o;
    logic [15:0] jtag_state_o, data_word_o;
    logic [7:0]  virtual_state_o, pout;
    logic [1:0]  node_enable_o;
    int          fail_count = 0;
    int          tests_run = 0;
    jhnf_row_s   rows [4] = '{'{8'h01, 4'h5, 8'h96, 2'b01}, '{8'h02, 4'ha, 8'h0f, 2'b10},
                             '{8'h01, 4'hf, 8'hff, 2'b01}, '{8'h02, 4'h0, 8'h00, 2'b10}};

    always #5 clk_i = ~clk_i;

    // user logic: instr bit 1 of each node picks one of two data chains
    always_comb begin
        data_cap[7:0]  = pout[1] ? 8'hc3 : 8'h3c;
        data_cap[15:8] = pout[5] ? 8'h5a : 8'ha5;
    end

    jhnf_host i_host (.clk_i(clk_i), .tdo_i(tdo_o), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
    jhnf_fabric #(.NODES(2), .VIR_W(4), .DATA_W(8), .FIFO_D(4)) i_dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdi_o(tdi_o), .tms_o(tms_o),
        .jtag_state_o(jtag_state_o), .virtual_state_o(virtual_state_o),
        .node_enable_o(node_enable_o), .node_instr_parallel_out_o(pout),
        .node_instr_capture_port_i(cap_port), .node_data_capture_i(data_cap),
        .data_valid_o(data_valid_o), .data_ready_i(data_ready_i), .data_word_o(data_word_o));

    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic give_verdict;
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // cut a hang short
    initial begin
        #500000;
        fail_count++;
        give_verdict();
    end

    // main sequence
    initial begin
        logic [31:0] d;
        logic        q;
        logic [7:0]  prev;
        logic [3:0]  pexp [1:2];
        int          n;
        prev = 8'h00;
        pexp[1] = 4'h0;
        pexp[2] = 4'h0;
        n = 0;
        repeat (20) @(negedge clk_i);
        reset_n_i <= 1'b1;
        repeat (4) @(negedge clk_i);
        check("state_reset", jtag_state_o, ST_TLR);
        i_host.tick(1'b0, 1'b0, q);
        foreach (rows[k]) begin
            i_host.scan(1'b1, 10, IR_INSTR_PATH, d);
            check("ir_capture", d[9:0], 10'h001);
            i_host.scan(1'b0, 12, {rows[k].node, rows[k].vir}, d);
            check("vir_sel", d[11:4], prev);
            if (prev != 8'h00) begin
                check("vir_capture", d[3:0], cap_port[prev*4-4 +: 4]);
            end
            prev = rows[k].node;
            pexp[rows[k].node] = rows[k].vir;
            repeat (6) @(negedge clk_i);
            check("enable", node_enable_o, rows[k].en);
            check("instr_out", pout, {pexp[2], pexp[1]});
            i_host.scan(1'b1, 10, IR_DATA_PATH, d);
            i_host.scan(1'b0, 8, rows[k].data, d);
            check("data_capture", d[7:0], data_cap[prev*8-8 +: 8]);
            repeat (6) @(negedge clk_i);
            check("fifo_valid", data_valid_o, 1'b1);
            check("fifo_word", data_word_o, {rows[k].node, rows[k].data});
            data_ready_i <= 1'b1;
            @(negedge clk_i);
            data_ready_i <= 1'b0;
        end
        // fill with the user stalled: four in fifo, one pending, one dropped
        for (int k = 0; k < 6; k++) begin
            i_host.scan(1'b0, 8, {4'h1, k[3:0]}, d);
        end
        data_ready_i <= 1'b1;
        repeat (20) begin
            if (data_valid_o === 1'b1) begin
                check("drain_word", data_word_o, {8'h02, 4'h1, n[3:0]});
                n++;
            end
            @(negedge clk_i);
        end
        check("drain_count", n, 5);
        // five tms-high ticks reach reset state and drop the node
        for (int k = 0; k < 5; k++) begin
            i_host.tick(1'b1, 1'b1, q);
        end
        repeat (8) @(negedge clk_i);
        check("tms_reset", jtag_state_o, ST_TLR);
        check("tms_desel", node_enable_o, 2'b00);
        check("tms_echo", tms_o, 1'b1);
        check("tdi_bcast", tdi_o, 1'b1);
        i_host.tick(1'b0, 1'b0, q);
        repeat (8) @(negedge clk_i);
        check("tms_idle", jtag_state_o, ST_RTI);
        // test reset pin while a node is selected
        i_host.scan(1'b1, 10, IR_INSTR_PATH, d);
        i_host.scan(1'b0, 12, {8'h01, 4'h3}, d);
        repeat (6) @(negedge clk_i);
        check("reselect", node_enable_o, 2'b01);
        trst_n_i <= 1'b0;
        repeat (6) @(negedge clk_i);
        check("trst_state", jtag_state_o, ST_TLR);
        check("trst_desel", node_enable_o, 2'b00);
        trst_n_i <= 1'b1;
        // fabric reset in mid-run
        i_host.tick(1'b0, 1'b0, q);
        i_host.scan(1'b1, 10, IR_INSTR_PATH, d);
        i_host.scan(1'b0, 12, {8'h02, 4'h7}, d);
        // leave a word standing in the fifo so the reset must clear it
        data_ready_i <= 1'b0;
        i_host.scan(1'b1, 10, IR_DATA_PATH, d);
        i_host.scan(1'b0, 8, 8'h42, d);
        check("rst_pre_valid", data_valid_o, 1'b1);
        reset_n_i <= 1'b0;
        repeat (3) @(negedge clk_i);
        check("rst_state", jtag_state_o, ST_TLR);
        check("rst_enable", node_enable_o, 2'b00);
        check("rst_instr", pout, 8'h00);
        check("rst_valid", data_valid_o, 1'b0);
        reset_n_i <= 1'b1;
        repeat (4) @(negedge clk_i);
        give_verdict();
    end
endmodule
